//--- pkg/usr_core_if.sv
/*
 usr_core_if: signals between the APB front end and the shift register core.
 Assumes both ends run on the same pclk and reset.
*/
`timescale 1ns/1ps
interface usr_core_if;
   import usr_pkg::*;

   logic                 step;
   logic                 load_select;
   logic                 serial_set;
   logic                 serial_keep_n;
   logic                 clear;
   logic [USR_WIDTH-1:0] parallel_in;
   logic [USR_WIDTH-1:0] stored;

   modport ctrl (
      output step,
      output load_select,
      output serial_set,
      output serial_keep_n,
      output clear,
      output parallel_in,
      input  stored
   );

   modport core (
      input  step,
      input  load_select,
      input  serial_set,
      input  serial_keep_n,
      input  clear,
      input  parallel_in,
      output stored
   );

endinterface

//--- pkg/usr_pkg.sv
/*
 usr_pkg: constants shared by the four-bit universal shift register block.
 Holds the register map of the APB slave, field positions, reset values and widths.
 Assumes a 32-bit APB data path with one aligned word per register.
*/
package usr_pkg;

   localparam int USR_WIDTH  = 4;
   localparam int USR_ADDR_W = 12;
   localparam int USR_DATA_W = 32;

   // register byte addresses
   localparam logic [USR_ADDR_W-1:0] USR_CTRL_OFS  = 12'h000;
   localparam logic [USR_ADDR_W-1:0] USR_PDATA_OFS = 12'h004;
   localparam logic [USR_ADDR_W-1:0] USR_STEP_OFS  = 12'h008;
   localparam logic [USR_ADDR_W-1:0] USR_STATE_OFS = 12'h00c;

   // control register fields
   localparam int USR_CTRL_LOAD   = 0;
   localparam int USR_CTRL_SET    = 1;
   localparam int USR_CTRL_KEEP_N = 2;
   localparam int USR_CTRL_POL    = 3;
   localparam int USR_CTRL_CLEAR  = 4;

   // state register fields
   localparam int USR_STATE_STORED_LSB = 0;
   localparam int USR_STATE_OUT_LSB    = 4;

   // reset values
   localparam logic                 USR_POL_RESET    = 1'h1;
   localparam logic                 USR_KEEP_N_RESET = 1'h1;
   localparam logic [USR_WIDTH-1:0] USR_DATA_RESET   = 4'h0;

endpackage

//--- rtl/usr_core.sv
/*
 usr_core: four storage stages with parallel load, right shift and a J/K first stage.
 Assumes step is a one-cycle pulse standing for one rising edge of shift_clock,
 and clear is a level that holds the stages at zero.
*/
`timescale 1ns/1ps
module usr_core
   import usr_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   usr_core_if.core  link
);

   logic [USR_WIDTH-1:0] stored;
   logic [USR_WIDTH-1:0] next_stored;
   logic [USR_WIDTH-1:0] shifted;
   logic                 first_stage;

   // j/k first stage: set, clear, toggle or hold
   function automatic logic jk_next(input logic j, input logic k_n, input logic q);
      jk_next = (j & ~q) | (k_n & q);
   endfunction

   assign first_stage = jk_next(link.serial_set, link.serial_keep_n, stored[0]);
   assign shifted     = {stored[USR_WIDTH-2:0], first_stage};

   assign next_stored = link.clear ? USR_DATA_RESET :
                        !link.step ? stored :
                        link.load_select ? link.parallel_in : shifted;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stored <= USR_DATA_RESET;
      end else begin
         stored <= next_stored;
      end
   end

   assign link.stored = stored;

endmodule

//--- rtl/usr_top.sv
/*
 usr_top: APB slave around a four-bit universal shift register.
 Software sets load select, serial inputs, polarity and clear in the control register,
 parallel data in its own register, and writes the step register to give one shift
 clock edge. Assumes an APB master on pclk; every access takes one wait state.
*/
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module usr_top
   import usr_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [USR_ADDR_W-1:0] paddr,
   input  wire logic [USR_DATA_W-1:0] pwdata,
   output logic      [USR_DATA_W-1:0] prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [USR_WIDTH-1:0]  parallel_out
);

   usr_core_if link ();

   usr_core u_core (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link.core)
   );

   // control and data registers
   logic                 load_select;
   logic                 serial_set;
   logic                 serial_keep_n;
   logic                 polarity;
   logic                 async_clear;
   logic [USR_WIDTH-1:0] parallel_in;
   logic                 step;

   // bus decode
   logic                  access_wait;
   logic                  access_done;
   logic                  wr_done;
   logic                  hit_ctrl;
   logic                  hit_pdata;
   logic                  hit_step;
   logic                  hit_state;
   logic                  addr_ok;
   logic [USR_DATA_W-1:0] rdata;
   logic [USR_DATA_W-1:0] ctrl_word;
   logic [USR_DATA_W-1:0] state_word;
   logic [USR_WIDTH-1:0]  next_out;

   function automatic logic addr_is(input logic [USR_ADDR_W-1:0] a,
                                    input logic [USR_ADDR_W-1:0] ofs);
      addr_is = (a == ofs);
   endfunction

   assign access_wait = psel & penable & ~pready;
   assign access_done = psel & penable & pready;
   assign wr_done     = access_done & pwrite;

   assign hit_ctrl  = addr_is(paddr, USR_CTRL_OFS);
   assign hit_pdata = addr_is(paddr, USR_PDATA_OFS);
   assign hit_step  = addr_is(paddr, USR_STEP_OFS);
   assign hit_state = addr_is(paddr, USR_STATE_OFS);
   assign addr_ok   = hit_ctrl | hit_pdata | hit_step | hit_state;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[USR_CTRL_LOAD]   = load_select;
      ctrl_word[USR_CTRL_SET]    = serial_set;
      ctrl_word[USR_CTRL_KEEP_N] = serial_keep_n;
      ctrl_word[USR_CTRL_POL]    = polarity;
      ctrl_word[USR_CTRL_CLEAR]  = async_clear;
   end

   always_comb begin
      state_word = '0;
      state_word[USR_STATE_STORED_LSB +: USR_WIDTH] = link.stored;
      state_word[USR_STATE_OUT_LSB +: USR_WIDTH]    = parallel_out;
   end

   assign rdata = hit_ctrl  ? ctrl_word :
                  hit_pdata ? USR_DATA_W'(parallel_in) :
                  hit_state ? state_word : '0;

   // apb answer: one wait state, data and error valid with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= access_wait;
         prdata  <= (access_wait & ~pwrite) ? rdata : '0;
         pslverr <= access_wait & ~addr_ok;
      end
   end

   // register writes take effect at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_select   <= 1'b0;
         serial_set    <= 1'b0;
         serial_keep_n <= USR_KEEP_N_RESET;
         polarity      <= USR_POL_RESET;
         async_clear   <= 1'b0;
      end else if (wr_done && hit_ctrl) begin
         load_select   <= pwdata[USR_CTRL_LOAD];
         serial_set    <= pwdata[USR_CTRL_SET];
         serial_keep_n <= pwdata[USR_CTRL_KEEP_N];
         polarity      <= pwdata[USR_CTRL_POL];
         async_clear   <= pwdata[USR_CTRL_CLEAR];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_in <= USR_DATA_RESET;
      end else if (wr_done && hit_pdata) begin
         parallel_in <= pwdata[USR_WIDTH-1:0];
      end
   end

   // a step write stands for one rising edge of shift_clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step <= 1'b0;
      end else begin
         step <= wr_done & hit_step;
      end
   end

   assign link.step          = step;
   assign link.load_select   = load_select;
   assign link.serial_set    = serial_set;
   assign link.serial_keep_n = serial_keep_n;
   assign link.clear         = async_clear;
   assign link.parallel_in   = parallel_in;

   // output polarity, registered from the stored bits
   assign next_out = polarity ? link.stored : ~link.stored;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_out <= USR_DATA_RESET;
      end else begin
         parallel_out <= next_out;
      end
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [USR_WIDTH-1:0] stored_w;
   assign stored_w = link.stored;

   a_load_parallel_in: assert property (
      step && load_select && !async_clear |=> stored_w == $past(parallel_in))
      else $error("parallel load did not take the data inputs");

   a_shift_upper_stages: assert property (
      step && !load_select && !async_clear
      |=> stored_w[USR_WIDTH-1:1] == $past(stored_w[USR_WIDTH-2:0]))
      else $error("upper stages did not shift right");

   a_serial_d_entry: assert property (
      step && !load_select && !async_clear && (serial_set == serial_keep_n)
      |=> stored_w[0] == $past(serial_set))
      else $error("first stage did not copy the serial input");

   a_serial_toggle: assert property (
      step && !load_select && !async_clear && serial_set && !serial_keep_n
      |=> stored_w[0] != $past(stored_w[0]))
      else $error("first stage did not toggle");

   a_serial_hold: assert property (
      step && !load_select && !async_clear && !serial_set && serial_keep_n
      |=> stored_w[0] == $past(stored_w[0]))
      else $error("first stage did not hold");

   a_out_polarity: assert property (
      ##1 parallel_out == ($past(polarity) ? $past(stored_w) : ~$past(stored_w)))
      else $error("output polarity does not match the stored bits");

   a_clear_empties: assert property (
      async_clear |=> stored_w == USR_DATA_RESET ##1 parallel_out == ($past(polarity) ?
         USR_DATA_RESET : ~USR_DATA_RESET))
      else $error("clear did not empty the stages");

   a_clear_overrides: assert property (
      async_clear [*2] |-> stored_w == USR_DATA_RESET)
      else $error("stages changed while clear stood");

   a_idle_stable: assert property (
      !step && !async_clear |=> $stable(stored_w))
      else $error("stages changed without a shift clock edge");

   a_one_edge_update: assert property (
      wr_done && hit_step ##1 !async_clear && !load_select
      |=> stored_w[USR_WIDTH-1:1] == $past(stored_w[USR_WIDTH-2:0]))
      else $error("step write did not give one shift edge");

   a_polarity_keeps_state: assert property (
      $changed(polarity) && !step && !async_clear |=> $stable(stored_w))
      else $error("polarity change altered the stored bits");

   a_apb_one_wait: assert property (
      access_wait |=> pready ##1 !pready)
      else $error("apb answer not after exactly one wait state");

endmodule

//--- verif/tb.sv
/*
 tb: self-checking bench for usr_top with random load and shift traffic.
 Assumes usr_apb_master drives the apb side.
*/
`timescale 1ns/1ps
module tb;
   import usr_pkg::*;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic                  psel, penable, pwrite, pready, pslverr, e;
   logic [USR_ADDR_W-1:0] paddr;
   logic [USR_DATA_W-1:0] pwdata, prdata, r;
   logic [USR_WIDTH-1:0]  parallel_out, q;
   logic [4:0]            c;
   int                    err_total = 0;
   int                    checked = 0;
   int                    seed = 32'he1259213;

   always #2.5 pclk = ~pclk;

   usr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .parallel_out(parallel_out));

   usr_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   task automatic cmp(input logic [USR_DATA_W-1:0] got, input logic [USR_DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [USR_ADDR_W-1:0] a, input logic [USR_DATA_W-1:0] d);
      m.xfer(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [USR_ADDR_W-1:0] a);
      m.xfer(1'b0, a, 32'h0, r, e);
   endtask

   function automatic logic [USR_WIDTH-1:0] nxt(input logic [USR_WIDTH-1:0] s,
                                                input logic [4:0] k,
                                                input logic [USR_WIDTH-1:0] d);
      logic s0;
      if (k[USR_CTRL_CLEAR])
         return '0;
      if (k[USR_CTRL_LOAD])
         return d;
      case ({k[USR_CTRL_SET], k[USR_CTRL_KEEP_N]})
         2'b11:   s0 = 1'b1;
         2'b00:   s0 = 1'b0;
         2'b10:   s0 = ~s[0];
         default: s0 = s[0];
      endcase
      return {s[2:0], s0};
   endfunction

   function automatic logic [USR_DATA_W-1:0] st(input logic [USR_WIDTH-1:0] s,
                                                input logic pol);
      return {24'h0, pol ? s : ~s, s};
   endfunction

   // control, data, one step, then read the state back
   task automatic step(input logic [4:0] k, input logic [USR_WIDTH-1:0] d);
      wr(USR_CTRL_OFS, {27'h0, k});
      wr(USR_PDATA_OFS, {28'h0, d});
      wr(USR_STEP_OFS, $random(seed));
      q = nxt(q, k, d);
      rd(USR_STATE_OFS);
   endtask

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      test_done();
   end

   initial begin
      q = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(USR_CTRL_OFS);
      cmp(r, 32'hc);
      rd(USR_STATE_OFS);
      cmp(r, 32'h0);
      rd(12'h010);
      cmp({31'h0, e}, 32'h1);
      wr(12'h010, 32'hffff_ffff);
      cmp({31'h0, e}, 32'h1);
      $display("test reset and map done");
      for (int i = 0; i < 48; i++) begin
         c = {1'b0, 4'($random(seed))};
         c[2:1] = i[1:0];
         step(c, 4'($random(seed)));
         cmp(r, st(q, c[3]));
         cmp({28'h0, parallel_out}, {28'h0, c[3] ? q : ~q});
         wr(USR_CTRL_OFS, {27'h0, c ^ 5'h08});
         rd(USR_STATE_OFS);
         cmp(r, st(q, ~c[3]));
      end
      $display("test load and shift done");
      step(5'h19, 4'hf);
      cmp(r, 32'h0);
      wr(USR_CTRL_OFS, 32'h10);
      rd(USR_STATE_OFS);
      cmp(r, 32'hf0);
      $display("test clear done");
      step(5'h09, 4'hf);
      cmp(r, st(4'hf, 1'b1));
      @(posedge pclk);
      presetn <= 1'b0;
      #1;
      cmp({28'h0, parallel_out}, 32'h0);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(USR_STATE_OFS);
      cmp(r, 32'h0);
      $display("test async reset done");
      test_done();
   end
endmodule

//--- verif/usr_apb_master.sv
/*
 usr_apb_master: apb master standing in for the logic around the register.
 Assumes a slave on pclk that ends each access with pready.
*/
`timescale 1ns/1ps
module usr_apb_master
   import usr_pkg::*;
(
   input  wire logic                  pclk,
   output logic                       psel,
   output logic                       penable,
   output logic                       pwrite,
   output logic      [USR_ADDR_W-1:0] paddr,
   output logic      [USR_DATA_W-1:0] pwdata,
   input  wire logic [USR_DATA_W-1:0] prdata,
   input  wire logic                  pready,
   input  wire logic                  pslverr
);
   initial begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= '0;
      pwdata  <= '0;
   end

   // one transfer; released address and data lines show inverted values, pwrite keeps its value
   task automatic xfer(input logic w, input logic [USR_ADDR_W-1:0] a,
                       input logic [USR_DATA_W-1:0] d, output logic [USR_DATA_W-1:0] r,
                       output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule
